//--- include/sync_line_map.svh
// field positions, reset values and timing counts of the sync line block
`ifndef SYNC_LINE_MAP_SVH
`define SYNC_LINE_MAP_SVH

// line parameter register (write only)
`define PRM_MODE_HI 13
`define PRM_MODE_LO 12
`define PRM_LEN_HI 11
`define PRM_LEN_LO 10
`define PRM_PARITY_ENABLE 9
`define PRM_PAR_SENSE 8
`define PRM_SYNC_HI 7
`define PRM_SYNC_LO 0
`define PRM_RESET 16'h0000

// transmit control register
`define TXC_FILL 15
`define TXC_LOOP 14
`define TXC_SSCLK 13
`define TXC_MS_HI 12
`define TXC_MS_LO 11
`define TXC_RXINP 10
`define TXC_MSTRST 8
`define TXC_DONE 7
`define TXC_DONE_IE 6
`define TXC_FILL_IE 5
`define TXC_SEND 4
`define TXC_HALFDUP 3
`define TXC_BREAK 0

// receive buffer register
`define RXB_PERR 12
`define RXB_DATA_RESET 8'hFF

// character length code 0 means this many data bits
`define CHAR_LEN_BASE 4'h5

// bit timing
`define CLK_PERIOD_NS 10
`define BIT_TIME_NS 10000
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- include/sync_line_pkg.sv
// types and shared decode of the sync line block
package sync_line_pkg;

    typedef enum logic [1:0] {
        MODE_ISO = 2'b00,
        MODE_ILLEGAL = 2'b01,
        MODE_EXT_SYNC = 2'b10,
        MODE_INT_SYNC = 2'b11
    } line_mode_e;

    typedef enum logic [1:0] {
        MAINT_NORMAL = 2'b00,
        MAINT_INT_LOOP = 2'b01,
        MAINT_EXT_LOOP = 2'b10,
        MAINT_SYS_TEST = 2'b11
    } maint_mode_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } tx_state_e;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_WAIT = 2'b01,
        RX_BITS = 2'b10,
        RX_STOP = 2'b11
    } rx_state_e;

    function automatic logic [7:0] len_mask(input logic [3:0] nbits);
        return 8'hFF >> (4'h8 - nbits);
    endfunction

endpackage

//--- rtl/parity_calc.sv
// parity bit over the low data bits of one character
`timescale 1ns/100ps
`default_nettype none

module parity_calc (
    input wire logic [7:0] data_i,
    input wire logic [3:0] nbits_i,
    input wire logic even_i,
    output logic par_o
);
    wire [7:0] used = data_i & sync_line_pkg::len_mask(nbits_i);

    // even sense: bit makes the ones count even, odd sense inverts it
    assign par_o = (^used) ^ ~even_i;
endmodule

`default_nettype wire

//--- rtl/sync_char_rx.sv
// receiver framing: sync hunt and character assembly
`timescale 1ns/100ps
`default_nettype none

module sync_char_rx (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic sample_i,
    input wire logic bit_i,
    input wire logic sync_mode_i,
    input wire logic [3:0] nbits_i,
    input wire logic [3:0] frame_i,
    input wire logic [7:0] sync_char_i,
    output logic [8:0] word_o,
    output logic valid_o,
    output logic synced_o
);
    sync_line_pkg::rx_state_e st;
    sync_line_pkg::rx_state_e next_st;
    logic [8:0] sh;
    logic [3:0] cnt;

    // lsb arrives first, so new bits enter at the top
    wire [8:0] sh_in = {bit_i, sh[8:1]};
    wire [8:0] word = sh_in >> (4'h9 - frame_i);
    // with parity on, the sync char's own parity bit closes the window
    wire [8:0] hunt = (sh_in >> (4'h9 - frame_i))
                    & {1'b0, sync_line_pkg::len_mask(nbits_i)};
    wire [7:0] want = sync_char_i & sync_line_pkg::len_mask(nbits_i);
    wire match = hunt == {1'b0, want};
    wire last = cnt == 4'(frame_i - 4'h1);

    always_comb begin
        next_st = st;
        unique case (st)
            sync_line_pkg::RX_HUNT: begin
                if (!sync_mode_i)
                    next_st = sync_line_pkg::RX_WAIT;
                else if (sample_i && match)
                    next_st = sync_line_pkg::RX_BITS;
            end
            sync_line_pkg::RX_WAIT: begin
                if (sync_mode_i)
                    next_st = sync_line_pkg::RX_HUNT;
                else if (sample_i && !bit_i)
                    next_st = sync_line_pkg::RX_BITS;
            end
            sync_line_pkg::RX_BITS: begin
                if (sample_i && last && !sync_mode_i)
                    next_st = sync_line_pkg::RX_STOP;
            end
            sync_line_pkg::RX_STOP: begin
                if (sample_i)
                    next_st = sync_mode_i ? sync_line_pkg::RX_HUNT
                                          : sync_line_pkg::RX_WAIT;
            end
        endcase
    end

    wire in_bits = st == sync_line_pkg::RX_BITS;
    wire done = sample_i && in_bits && last;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= sync_line_pkg::RX_HUNT;
            sh <= 9'h000;
            cnt <= 4'h0;
            word_o <= 9'h000;
            valid_o <= 1'b0;
        end else if (clr_i) begin
            st <= sync_line_pkg::RX_HUNT;
            sh <= 9'h000;
            cnt <= 4'h0;
            valid_o <= 1'b0;
        end else begin
            st <= next_st;
            if (sample_i)
                sh <= sh_in;
            if (!in_bits || done)
                cnt <= 4'h0;
            else if (sample_i)
                cnt <= 4'(cnt + 4'h1);
            valid_o <= done;
            if (done)
                word_o <= word;
        end
    end

    assign synced_o = sync_mode_i && in_bits;
endmodule

`default_nettype wire

//--- rtl/sync_line_parity_fill.sv
// parameter register, transmitter with fill, receive buffer of the line
`timescale 1ns/100ps
`default_nettype none
`include "sync_line_map.svh"

// Overview of operation
// - parity enabled: transmitter appends parity, receiver checks every char
// - parity with under eight bits: received parity bit lands in buffer
// - received parity mismatch sets parity error flag, receive buffer bit 12
// - parity sense set means even parity, cleared means odd, both ways
// - transmitter computes parity; processor supplies data bits only
// - receiver matches incoming bits to sync character to gain sync
// - synchronous mode, nothing loaded in time: sync character sent as fill
// - fill sent sets fill flag, transmit control bit 15, sync mode only
// - fill flag set with fill interrupt enable bit 5 raises interrupt
// - fill flag cleared by initialize, master reset, transmit control read
// - loop maintenance modes: bit 14 drives receiver input instead of line
// - loopback bit cleared by initialize or master reset
// - mode field: 11 internal sync, 10 external sync, 00 iso, 01 illegal
// - length field codes 00..11 give 5, 6, 7, 8 data bits
// - transmit done with its enable bit 6 raises interrupt too

module sync_line_parity_fill #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic init_i,
    input wire logic [15:0] wdata_i,
    input wire logic param_wr_i,
    input wire logic transmit_control_register_wr_i,
    input wire logic transmit_csr_read_strobe_i,
    input wire logic tx_load_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_line_i,
    output logic [15:0] transmit_control_register_o,
    output logic [15:0] rxbuf_o,
    output logic rx_valid_o,
    output logic rx_synced_o,
    output logic tx_line_o,
    output logic tx_irq_o
);
    // ---- line parameter register
    logic parity_enable;
    logic parity_sense_select;
    logic [1:0] line_mode;
    logic [1:0] char_length_select;
    logic [7:0] sync_char;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {line_mode, char_length_select, parity_enable,
             parity_sense_select, sync_char} <= 14'(`PRM_RESET);
        end else if (param_wr_i) begin
            line_mode <= wdata_i[`PRM_MODE_HI:`PRM_MODE_LO];
            char_length_select <= wdata_i[`PRM_LEN_HI:`PRM_LEN_LO];
            parity_enable <= wdata_i[`PRM_PARITY_ENABLE];
            parity_sense_select <= wdata_i[`PRM_PAR_SENSE];
            sync_char <= wdata_i[`PRM_SYNC_HI:`PRM_SYNC_LO];
        end
    end

    // the illegal code is run as isochronous
    wire sync_mode = line_mode == sync_line_pkg::MODE_INT_SYNC
                  || line_mode == sync_line_pkg::MODE_EXT_SYNC;
    wire [3:0] nbits =
        4'(`CHAR_LEN_BASE + {2'b00, char_length_select});
    wire [3:0] frame = 4'(nbits + {3'b000, parity_enable});

    // ---- transmit control register
    logic loopback_serial_bit;
    logic ss_clk;
    logic [1:0] maint;
    logic done_ie;
    logic fill_interrupt_enable;
    logic send;
    logic half_dup;
    logic brk;
    logic mst_pulse;

    // master reset is a one-cycle clear here, not the long bus pulse
    wire clr = init_i || mst_pulse;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {loopback_serial_bit, ss_clk, maint} <= 4'h0;
            {done_ie, fill_interrupt_enable} <= 2'h0;
            {send, half_dup, brk} <= 3'h0;
            mst_pulse <= 1'b0;
        end else begin
            mst_pulse <= transmit_control_register_wr_i && wdata_i[`TXC_MSTRST];
            if (clr) begin
                {loopback_serial_bit, ss_clk, maint} <= 4'h0;
                {done_ie, fill_interrupt_enable} <= 2'h0;
                {send, half_dup, brk} <= 3'h0;
            end else if (transmit_control_register_wr_i) begin
                loopback_serial_bit <= wdata_i[`TXC_LOOP];
                ss_clk <= wdata_i[`TXC_SSCLK];
                maint <= wdata_i[`TXC_MS_HI:`TXC_MS_LO];
                done_ie <= wdata_i[`TXC_DONE_IE];
                fill_interrupt_enable <= wdata_i[`TXC_FILL_IE];
                send <= wdata_i[`TXC_SEND];
                half_dup <= wdata_i[`TXC_HALFDUP];
                brk <= wdata_i[`TXC_BREAK];
            end
        end
    end

    wire loop_mode = maint == sync_line_pkg::MAINT_INT_LOOP
                  || maint == sync_line_pkg::MAINT_EXT_LOOP;

    // ---- bit timing: transmit on the end tick, sample at mid bit
    logic [15:0] baud_cnt;
    wire tick_end = baud_cnt == 16'(BIT_CYCLES - 1);
    wire tick_mid = baud_cnt == 16'(BIT_CYCLES / 2);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            baud_cnt <= 16'h0000;
        else
            baud_cnt <= tick_end ? 16'h0000 : 16'(baud_cnt + 16'h0001);
    end

    // ---- transmitter
    sync_line_pkg::tx_state_e tx_st;
    sync_line_pkg::tx_state_e next_tx_st;
    logic [7:0] tx_buf;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_par;
    logic tx_done;
    logic take_buf;
    logic fill_sent;
    logic next_par;

    wire in_data = tx_st == sync_line_pkg::TX_DATA;
    wire in_par = tx_st == sync_line_pkg::TX_PAR;
    wire last_data = in_data && tx_cnt == 4'(nbits - 4'h1);
    wire last_bit = (last_data && !parity_enable) || in_par;
    wire char_end = tick_end && last_bit;
    wire start_idle = tick_end && tx_st == sync_line_pkg::TX_IDLE && !tx_done;
    // sync mode chains characters back to back with no idle gap
    wire chain = char_end && sync_mode;
    wire fill_load = chain && !take_buf;
    wire buf_load = start_idle || (chain && take_buf);
    wire char_load = buf_load || fill_load;
    wire [7:0] next_char = fill_load ? sync_char : tx_buf;
    // a load while the buffer is still full would overwrite a character
    wire load_ok = tx_load_i && tx_done;

    parity_calc u_tx_par (
        .data_i(next_char),
        .nbits_i(nbits),
        .even_i(parity_sense_select),
        .par_o(next_par)
    );

    always_comb begin
        next_tx_st = tx_st;
        if (char_load) begin
            next_tx_st = sync_mode ? sync_line_pkg::TX_DATA
                                   : sync_line_pkg::TX_START;
        end else if (tick_end) begin
            unique case (tx_st)
                sync_line_pkg::TX_IDLE:
                    next_tx_st = sync_line_pkg::TX_IDLE;
                sync_line_pkg::TX_START:
                    next_tx_st = sync_line_pkg::TX_DATA;
                sync_line_pkg::TX_DATA: begin
                    if (last_data)
                        next_tx_st = parity_enable ? sync_line_pkg::TX_PAR
                                                   : sync_line_pkg::TX_STOP;
                end
                sync_line_pkg::TX_PAR:
                    next_tx_st = sync_line_pkg::TX_STOP;
                sync_line_pkg::TX_STOP:
                    next_tx_st = sync_line_pkg::TX_IDLE;
                default:
                    next_tx_st = sync_line_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st <= sync_line_pkg::TX_IDLE;
            tx_sh <= 8'h00;
            tx_cnt <= 4'h0;
            tx_par <= 1'b0;
        end else if (clr) begin
            tx_st <= sync_line_pkg::TX_IDLE;
            tx_cnt <= 4'h0;
        end else begin
            tx_st <= next_tx_st;
            if (char_load) begin
                tx_sh <= next_char;
                tx_cnt <= 4'h0;
                tx_par <= next_par;
            end else if (tick_end && in_data) begin
                tx_sh <= {1'b0, tx_sh[7:1]};
                tx_cnt <= 4'(tx_cnt + 4'h1);
            end
        end
    end

    // buffer empty flag doubles as transmit done
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_buf <= 8'h00;
            tx_done <= 1'b1;
            take_buf <= 1'b0;
        end else if (clr) begin
            tx_done <= 1'b1;
            take_buf <= 1'b0;
        end else begin
            if (load_ok)
                tx_buf <= tx_data_i;
            if (buf_load)
                tx_done <= 1'b1;
            else if (load_ok)
                tx_done <= 1'b0;
            // decided half a bit early; a later load waits a character
            if (tick_mid && last_bit)
                take_buf <= !tx_done;
        end
    end

    // hardware set beats the read clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            fill_sent <= 1'b0;
        else if (clr)
            fill_sent <= 1'b0;
        else if (fill_load)
            fill_sent <= 1'b1;
        else if (transmit_csr_read_strobe_i)
            fill_sent <= 1'b0;
    end

    wire line_bit = in_data ? tx_sh[0]
                  : in_par ? tx_par
                  : tx_st != sync_line_pkg::TX_START;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            tx_line_o <= 1'b1;
        else
            tx_line_o <= line_bit;
    end

    assign tx_irq_o = (fill_sent && fill_interrupt_enable)
                   || (tx_done && done_ie);

    // ---- receiver
    logic rx_meta;
    logic rx_sync;
    logic [8:0] rx_word;
    logic rx_word_valid;
    logic rx_calc;
    logic [7:0] rx_data;
    logic parity_error_flag;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_line_i;
            rx_sync <= rx_meta;
        end
    end

    wire rx_in = loop_mode ? loopback_serial_bit : rx_sync;

    // free running sampler: iso start edges are not re-centred
    sync_char_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(clr),
        .sample_i(tick_mid),
        .bit_i(rx_in),
        .sync_mode_i(sync_mode),
        .nbits_i(nbits),
        .frame_i(frame),
        .sync_char_i(sync_char),
        .word_o(rx_word),
        .valid_o(rx_word_valid),
        .synced_o(rx_synced_o)
    );

    parity_calc u_rx_par (
        .data_i(rx_word[7:0]),
        .nbits_i(nbits),
        .even_i(parity_sense_select),
        .par_o(rx_calc)
    );

    wire rx_par_bit = rx_word[nbits];
    wire rx_bad = parity_enable && rx_par_bit != rx_calc;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_data <= `RXB_DATA_RESET;
            parity_error_flag <= 1'b0;
            rx_valid_o <= 1'b0;
        end else if (clr) begin
            rx_data <= `RXB_DATA_RESET;
            parity_error_flag <= 1'b0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= rx_word_valid;
            if (rx_word_valid) begin
                // parity sits just above the data when it fits
                rx_data <= rx_word[7:0];
                parity_error_flag <= rx_bad;
            end
        end
    end

    assign rxbuf_o = 16'(rx_data)
                   | (16'(parity_error_flag) << `RXB_PERR);
    assign transmit_control_register_o = {fill_sent, loopback_serial_bit, ss_clk, maint,
                      rx_in, 2'b00, tx_done, done_ie,
                      fill_interrupt_enable, send, half_dup, 2'b00, brk};

    // ---- checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_fill_sets_flag: assert property (
        fill_load && !clr |=> fill_sent)
        else $error("fill sent without setting the flag");

    a_fill_only_sync: assert property (
        $rose(fill_sent) |-> $past(sync_mode))
        else $error("fill flag rose outside synchronous mode");

    a_fill_char_sent: assert property (
        fill_load && !clr |=> tx_sh == $past(sync_char))
        else $error("fill character is not the sync character");

    a_fill_irq_raise: assert property (
        fill_load && fill_interrupt_enable && !clr |=> tx_irq_o)
        else $error("fill with enable gave no interrupt");

    a_done_irq_raise: assert property (
        buf_load && done_ie && !clr |=> tx_irq_o)
        else $error("transmit done with enable gave no interrupt");

    a_fill_read_clear: assert property (
        transmit_csr_read_strobe_i && !fill_load |=> !fill_sent)
        else $error("control read left the fill flag set");

    a_loop_bit_clear: assert property (
        clr |=> !loopback_serial_bit)
        else $error("loopback bit survived a clear");

    a_loop_input: assert property (
        loop_mode && loopback_serial_bit != rx_sync
        |-> rx_in == loopback_serial_bit)
        else $error("receiver not fed from loopback bit");

    a_perr_set: assert property (
        rx_word_valid && rx_bad && !clr |=> parity_error_flag)
        else $error("parity mismatch did not set the error flag");

    a_perr_off: assert property (
        rx_word_valid && !parity_enable && !clr |=> !parity_error_flag)
        else $error("parity error set with parity disabled");

    a_late_load_fill: assert property (
        chain && tx_done |-> fill_load)
        else $error("empty buffer at character end sent no fill");
endmodule

`default_nettype wire

//--- rtl/sync_char_rx_fix.sv
// holds no logic; receiver framing is in sync_char_rx

//--- sim/line_peer.sv
// far end of the serial line: sends receive frames, watches transmit data
`timescale 1ns/100ps
`default_nettype none

module line_peer #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    logic [8*BIT_CYCLES-1:0] hist = '1;

    initial line_o = 1'b1;

    always @(posedge clk_i) begin
        hist <= {line_i, hist[8*BIT_CYCLES-1:1]};
    end

    // lsb first; line back to mark level once the last bit has run out
    task automatic send_bits(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            line_o = v[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_i);
        end
        @(negedge clk_i);
        line_o = 1'b1;
    endtask

    // start bit is consumed, then n bits sampled mid-bit
    task automatic catch_bits(input int n, output logic [15:0] v);
        v = 16'h0000;
        @(negedge line_i);
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_i);
            v[i] = line_i;
        end
    endtask

    // sliding window, so no bit alignment is assumed
    task automatic hunt(input logic [7:0] c, output logic found);
        logic [8*BIT_CYCLES-1:0] pat;
        for (int i = 0; i < 8 * BIT_CYCLES; i++) begin
            pat[i] = c[i / BIT_CYCLES];
        end
        found = 1'b0;
        for (int k = 0; k < 400 && !found; k++) begin
            @(posedge clk_i);
            #1;
            found = (hist === pat);
        end
    endtask
endmodule

`default_nettype wire

//--- sim/test_sync_line_parity_fill.sv
// self-checking bench of the parity, sync and fill block
`timescale 1ns/100ps
`default_nettype none

module test_sync_line_parity_fill;
    localparam int BC = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic init_i = 1'b0;
    logic [15:0] wdata_i = 16'h0000;
    logic param_wr_i = 1'b0;
    logic transmit_control_register_wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic tx_load_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic rx_line;
    logic [15:0] transmit_control_register_o;
    logic [15:0] rxbuf_o;
    logic rx_valid_o;
    logic rx_synced_o;
    logic tx_line_o;
    logic tx_irq_o;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    sync_line_parity_fill #(.BIT_CYCLES(BC)) sync_line_parity_fill_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .init_i(init_i),
        .wdata_i(wdata_i),
        .param_wr_i(param_wr_i),
        .transmit_control_register_wr_i(transmit_control_register_wr_i),
        .transmit_csr_read_strobe_i(rd_i),
        .tx_load_i(tx_load_i),
        .tx_data_i(tx_data_i),
        .rx_line_i(rx_line),
        .transmit_control_register_o(transmit_control_register_o),
        .rxbuf_o(rxbuf_o),
        .rx_valid_o(rx_valid_o),
        .rx_synced_o(rx_synced_o),
        .tx_line_o(tx_line_o),
        .tx_irq_o(tx_irq_o)
    );

    line_peer #(.BIT_CYCLES(BC)) line_peer_inst (
        .clk_i(clk_i),
        .line_i(tx_line_o),
        .line_o(rx_line)
    );

    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // settle time covers master reset and the line synchroniser
    task automatic wr(input logic ctl, input logic [15:0] v);
        @(negedge clk_i);
        wdata_i = v;
        param_wr_i = !ctl;
        transmit_control_register_wr_i = ctl;
        @(negedge clk_i);
        param_wr_i = 1'b0;
        transmit_control_register_wr_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic load(input logic [7:0] d);
        @(negedge clk_i);
        tx_data_i = d;
        tx_load_i = 1'b1;
        @(negedge clk_i);
        tx_load_i = 1'b0;
    endtask

    task automatic init_pulse;
        @(negedge clk_i);
        init_i = 1'b1;
        @(negedge clk_i);
        init_i = 1'b0;
    endtask

    task automatic wait_for(input logic fill);
        int n;
        n = 0;
        while (n < 600 && ((fill ? transmit_control_register_o[15] : rx_valid_o) !== 1'b1)) begin
            @(negedge clk_i);
            n++;
        end
        chk({15'h0000, n < 600}, 16'h0001);
    endtask

    initial begin
        logic [15:0] v;
        logic found;
        logic par;
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        chk(transmit_control_register_o & 16'hFBFF, 16'h0080);
        chk(rxbuf_o, 16'h00FF);
        chk({14'h0000, tx_line_o, tx_irq_o}, 16'h0002);
        wr(1'b1, 16'h4860);
        chk(transmit_control_register_o & 16'hFBFF, 16'h48E0);
        chk({15'h0000, transmit_control_register_o[10]}, 16'h0001);
        chk({15'h0000, tx_irq_o}, 16'h0001);
        wr(1'b1, 16'h0800);
        chk({15'h0000, transmit_control_register_o[10]}, 16'h0000);
        wr(1'b1, 16'h4160);
        chk(transmit_control_register_o & 16'hFBFF, 16'h0080);
        for (int s = 0; s < 2; s++) begin
            wr(1'b0, {7'h01, s[0], 8'h00});
            par = ^5'h15 ^ !s[0];
            fork
                line_peer_inst.catch_bits(7, v);
                load(8'h15);
            join
            chk(v, {9'h000, 1'b1, par, 5'h15});
            repeat (2 * BC) @(negedge clk_i);
        end
        chk({15'h0000, transmit_control_register_o[15]}, 16'h0000);
        wr(1'b0, 16'h0300);
        for (int k = 0; k < 2; k++) begin
            par = ^5'h0B ^ k[0];
            fork
                line_peer_inst.send_bits({8'h00, 1'b1, par, 5'h0B, 1'b0}, 8);
                wait_for(1'b0);
            join
            chk(rxbuf_o, {3'h0, k[0], 6'h00, par, 5'h0B});
        end
        init_pulse;
        wr(1'b0, 16'h2C96);
        wr(1'b1, 16'h0020);
        // no reload after the first character, so fill must follow
        fork
            line_peer_inst.hunt(8'h96, found);
            begin
                load(8'h00);
                wait_for(1'b1);
            end
        join
        chk({15'h0000, found}, 16'h0001);
        chk({15'h0000, tx_irq_o}, 16'h0001);
        @(negedge clk_i);
        rd_i = 1'b1;
        chk({15'h0000, transmit_control_register_o[15]}, 16'h0001);
        @(negedge clk_i);
        rd_i = 1'b0;
        chk({14'h0000, transmit_control_register_o[15], tx_irq_o}, 16'h0000);
        init_pulse;
        wr(1'b0, 16'h3C96);
        fork
            line_peer_inst.send_bits({8'h3C, 8'h96}, 16);
            wait_for(1'b0);
        join
        chk({8'h00, rxbuf_o[7:0]}, 16'h003C);
        chk({15'h0000, rx_synced_o}, 16'h0001);
        report_and_stop;
    end
endmodule

`default_nettype wire
